// ==== dv/elc_partner.sv ====
// Link partner model: capability words, line bits, end codes, pause frames
// Assumes the bench calls its tasks by hierarchical name
`timescale 1ns/100ps
module elc_partner (
  // Clock
  input wire logic sys_clk,
  // Toward the block
  output logic flp_rx_vld,
  output logic [15:0] flp_rx_word,
  output logic line_rx_bit,
  output logic rx_end,
  output logic link_ok,
  output elc_pkg::elc_ctl_s ctl_frm
);
  import elc_pkg::*;
  // Quiet line at time zero, idle level is one
  initial begin
    {flp_rx_vld, flp_rx_word, rx_end, link_ok, ctl_frm} = '0;
    line_rx_bit = 1'b1;
  end
  // One capability word; word bus scrambled afterwards so no stale hold
  task automatic word(input logic [15:0] w);
    @(posedge sys_clk);
    link_ok <= 1'b1;
    flp_rx_vld <= 1'b1;
    flp_rx_word <= w;
    @(posedge sys_clk);
    flp_rx_vld <= 1'b0;
    flp_rx_word <= ~w;
  endtask
  // Control frame, taken as sent to the reserved group or to us
  task automatic pause(input logic [15:0] op, input logic [15:0] prm);
    @(posedge sys_clk);
    ctl_frm <= '{1'b1, op, prm};
    @(posedge sys_clk);
    ctl_frm <= '{1'b0, ~op, ~prm};
  endtask
  // Alternating bits give two spaced zeros in any ten-bit span
  task automatic burst();
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      line_rx_bit <= i[0];
    end
  endtask
  // End-of-stream code for one cycle; line bit left at its last value
  task automatic stop();
    @(posedge sys_clk);
    rx_end <= 1'b1;
    @(posedge sys_clk);
    rx_end <= 1'b0;
  endtask
endmodule

// ==== dv/tb_ethernet_link_control.sv ====
// Self-checking bench for the link control block
// Assumes the partner model and a zero-wait register slave
`timescale 1ns/100ps
module tb_ethernet_link_control;
  import elc_pkg::*;
  logic sys_clk, rst_b, hsel, hwrite, tx_nrzi_bit, tx_en, hreadyout;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic flp_rx_vld, line_rx_bit, rx_end, link_ok, rx_path_bit, line_tx_oe, tx_start_ok;
  logic crs, col, spd100, full_dup, flp_tx_en;
  logic tx_manch_bit, line_tx_bit, rx_ok, pme_b_oe;
  elc_rxb_s rxb;
  logic [15:0] flp_rx_word, flp_tx_word;
  elc_ctl_s ctl_frm;
  int fails = 0, compares = 0;
  elc_partner p (.sys_clk(sys_clk), .flp_rx_vld(flp_rx_vld), .flp_rx_word(flp_rx_word),
    .line_rx_bit(line_rx_bit), .rx_end(rx_end), .link_ok(link_ok), .ctl_frm(ctl_frm));
  elc_link_ctrl #(.SLOT10_CYC(16), .ACT_HALF(4), .COL_HALF(2)) dut (.sys_clk(sys_clk),
    .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(),
    .hrdata(hrdata), .line_rx_bit(line_rx_bit), .tx_nrzi_bit(tx_nrzi_bit),
    .tx_manch_bit(tx_manch_bit), .rx_end(rx_end), .rx_path_bit(rx_path_bit),
    .line_tx_bit(line_tx_bit), .line_tx_oe(line_tx_oe), .tx_en(tx_en),
    .tx_start_ok(tx_start_ok), .rx_ok(rx_ok), .crs(crs),
    .col(col), .spd100(spd100), .full_dup(full_dup), .flp_rx_vld(flp_rx_vld),
    .flp_rx_word(flp_rx_word), .link_ok(link_ok), .flp_tx_en(flp_tx_en),
    .flp_tx_word(flp_tx_word), .ctl_frm(ctl_frm), .rxb(rxb), .pme_b_o(), .pme_b_oe(pme_b_oe),
    .led());
  // Clock and time-zero inputs
  initial begin
    sys_clk = 0;
    {rst_b, hsel, hwrite, htrans, hsize, haddr, hwdata, tx_nrzi_bit, tx_en, tx_manch_bit, rxb} = '0;
    forever #5 sys_clk = ~sys_clk;
  end
  // One AHB-Lite single word transfer, waits on hready each phase
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1; haddr <= a; hwrite <= w; htrans <= 2'b10; hsize <= 3'b010;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00; hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Wake frame: six FF, sixteen address copies, good verdicts on the last byte
  task automatic wake_frame(input logic [47:0] m);
    for (int i = 0; i < 103; i++) begin
      @(posedge sys_clk);
      rxb <= '{1'b1, (i < 6) ? 8'hFF : (i < 102) ? m[((i - 6) % 6) * 8 +: 8] : 8'h00,
        i == 102, 1'b1, 1'b1};
    end
    @(posedge sys_clk);
    rxb <= '0;
  endtask
  task automatic final_report();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog well beyond the planned sequence
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    final_report();
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_b <= 1;
    wait_n(2);
    chk("flp_en", flp_tx_en, 1);
    chk("flp_word", flp_tx_word, 16'h05E1);
    p.word(16'h05E1);
    wait_n(3);
    chk("mode", {spd100, full_dup}, 2'b11);
    xfer(0, 32'h18, 0);
    chk("pause_en", rd[6], 1);
    p.pause(16'h0001, 16'h0001);
    wait_n(1);
    chk("paused", tx_start_ok, 0);
    wait_n(400);
    chk("hold", tx_start_ok, 0);
    wait_n(200);
    chk("expire", tx_start_ok, 1);
    p.pause(16'h0002, 16'h0100);
    wait_n(2);
    chk("bad_op", tx_start_ok, 1);
    p.pause(16'h0001, 16'h0100);
    p.pause(16'h0001, 16'h0000);
    wait_n(2);
    chk("zero", tx_start_ok, 1);
    p.burst();
    wait_n(2);
    chk("crs_on", crs, 1);
    p.stop();
    wait_n(3);
    chk("crs_off", crs, 0);
    xfer(1, 32'h04, 32'h8000 | 32'h3100);
    wait_n(1);
    xfer(0, 32'h04, 0);
    chk("prst", rd, 32'h3100);
    p.word(16'h0021);
    wait_n(3);
    chk("mode10h", {spd100, full_dup}, 2'b00);
    xfer(1, 32'h04, 32'h2000);
    tx_en <= 1;
    p.burst();
    wait_n(2);
    chk("half", {spd100, full_dup, crs, col}, 4'b1011);
    xfer(1, 32'h04, 32'h2100);
    wait_n(3);
    chk("full", {full_dup, col}, 2'b10);
    tx_en <= 0;
    p.stop();
    xfer(1, 32'h04, 32'h6100);
    tx_nrzi_bit <= 0;
    wait_n(3);
    chk("lbk", {line_tx_oe, rx_path_bit}, 2'b00);
    tx_nrzi_bit <= 1;
    wait_n(3);
    chk("lbk1", rx_path_bit, 1);
    xfer(1, 32'h04, 32'h4100);
    tx_manch_bit <= 1;
    tx_nrzi_bit <= 0;
    wait_n(3);
    chk("lbk10", rx_path_bit, 1);
    xfer(1, 32'h04, 32'h2100);
    xfer(1, 32'h0C, 32'h0008);
    wait_n(2);
    chk("rlbk", {line_tx_oe, line_tx_bit}, 2'b11);
    xfer(1, 32'h1C, 32'h5678_9ABC);
    xfer(1, 32'h20, 32'h1234);
    xfer(1, 32'h10, 32'h0004_0000);
    wake_frame(48'h1234_5678_9ABC);
    wait_n(1);
    chk("pme", pme_b_oe, 1);
    xfer(0, 32'h14, 0);
    chk("pme_sts", rd[15], 1);
    xfer(0, 32'h40, 0);
    chk("unmapped", rd, 0);
    xfer(1, 32'h00, 1);
    wait_n(3);
    xfer(0, 32'h04, 0);
    chk("swrst", rd, 32'h3100);
    xfer(1, 32'h14, 32'h2);
    wait_n(1);
    chk("d2", {rx_ok, tx_start_ok}, 0);
    xfer(0, 32'h04, 0);
    chk("d2_rd", rd, 0);
    final_report();
  end
endmodule

// ==== src/elc_link_ctrl.sv ====
// Link-side control of a 10/100 Ethernet controller with transceiver
// Assumes one 100 MHz clock; serial coders, MAC and FLP engine outside
//
// What this block does
// - Carrier on two spaced zeros, off at end
// - Half duplex carrier includes transmit; full not
// - Collision only in half duplex overlap
// - Control bit 14 isolates line, internal loopback
// - Bit 3 of reg 21: remote loopback, 100M
// - 100M loopback: NRZI output into receive
// - Remote loopback: recovered data back to line
// - 10M loopback: Manchester output into PLL
// - Bit 12 enables negotiation, else fixed mode
// - Pulse burst carries advertised 16-bit word
// - Resolve 100F, 100H, 10F, 10H priority
// - Negotiation starts at reset when enabled
// - Pause only after full duplex pause negotiated
// - Opcode 0001h with slot-time parameter
// - Timer loads duration; zero ends pause
// - Running frame finishes; new starts blocked
// - Three or four LED schemes, 10/20 Hz
// - Pin reset 100us; bit 0 self-clearing reset
// - Control bit 15 resets transceiver, self-clears
// - Wake pattern sets status, drives wake pin
// - D1 wake only; D2 no traffic at all
`timescale 1ns/100ps
`include "elc_params.svh"
module elc_link_ctrl #(
  parameter int unsigned SLOT10_CYC = `ELC_SLOT10_CYC, // Slot at 10 Mb/s
  parameter int unsigned ACT_HALF = `ELC_ACT_HALF, // Half blink, activity
  parameter int unsigned COL_HALF = `ELC_COL_HALF // Half blink, collision
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Serial paths
  input wire logic line_rx_bit,
  input wire logic tx_nrzi_bit,
  input wire logic tx_manch_bit,
  input wire logic rx_end,
  output logic rx_path_bit,
  output logic line_tx_bit,
  output logic line_tx_oe,
  // MAC side
  input wire logic tx_en,
  output logic tx_start_ok,
  output logic rx_ok,
  output logic crs,
  output logic col,
  output logic spd100,
  output logic full_dup,
  // Negotiation pulses and link test
  input wire logic flp_rx_vld,
  input wire logic [15:0] flp_rx_word,
  input wire logic link_ok,
  output logic flp_tx_en,
  output logic [15:0] flp_tx_word,
  // Received frames
  input wire elc_pkg::elc_ctl_s ctl_frm,
  input wire elc_pkg::elc_rxb_s rxb,
  // Wake pin, open drain, and LEDs
  output logic pme_b_o,
  output logic pme_b_oe,
  output logic [3:0] led
);
  import elc_pkg::*;

  // ==========================================
  // Decode helpers
  // ==========================================
  // Asleep states answer only the power register
  function automatic logic acc_ok(input elc_pwr_e p, input logic [7:0] a);
    return (p == ELC_D0) || (a == `ELC_A_PWR);
  endfunction

  // Any two zeros with at least one bit between them
  function automatic logic zeros2(input logic [9:0] w);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 8; i++) begin
      for (int j = i + 2; j < 10; j++) begin
        if (!w[i] && !w[j]) hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // Station address byte, first on wire is lowest
  function automatic logic [7:0] mac_byte(input logic [47:0] m, input logic [2:0] p);
    return m[p*8 +: 8];
  endfunction

  // ==========================================
  // Registers and state
  // ==========================================
  logic wph_r; // Write data phase pending
  logic [7:0] ph_a_r; // Latched address
  logic [31:0] hrdata_r; // Read data
  logic sw_rst_r; // Whole-block reset request
  logic [15:0] pctl_r; // Transceiver control
  logic [15:0] padv_r; // Advertised abilities
  logic [15:0] pspc_r; // Transceiver specific control
  logic [31:0] rcfg_r; // Recall configuration
  elc_pwr_e pwr_r; // Power state
  logic pme_sts_r; // Wake status, sticky
  logic [31:0] macl_r; // Station address low
  logic [15:0] mach_r; // Station address high
  elc_an_e an_r, an_nxt; // Negotiation state
  logic [1:0] res_r; // Resolved {speed100, full}
  logic pse_r; // Both sides offer pause
  logic [9:0] sr_r; // Receive bit window
  logic crs_rx_r; // Receive carrier
  logic crs_r, col_r; // Registered MAC indications
  logic rx_path_r, line_tx_r, line_oe_r; // Registered serial outputs
  logic [15:0] ptime_r; // Pause slots left
  logic [12:0] slot_r; // Cycles inside the slot
  logic [2:0] ff_r, pos_r; // Wake FF count, address byte
  logic [3:0] rep_r; // Wake address copies seen
  logic found_r; // Wake pattern seen this frame
  logic wake_hit; // Wake frame accepted on its last byte
  logic [22:0] act_cnt_r, col_cnt_r; // Blink dividers
  logic act_blk_r, col_blk_r; // Blink phases
  logic [3:0] led_r; // LED drive

  // ==========================================
  // Bus decode
  // ==========================================
  wire addr_ph = hsel & htrans[1] & hready; // Accepted address phase
  wire [7:0] a = haddr[7:0];
  wire chip_rst = sw_rst_r;
  wire phy_rst = pctl_r[`ELC_B_PRST];
  wire phy_clr = chip_rst | phy_rst;
  wire we_bm = wph_r & (ph_a_r == `ELC_A_BMODE);
  wire we_pc = wph_r & (ph_a_r == `ELC_A_PCTL);
  wire we_pa = wph_r & (ph_a_r == `ELC_A_PADV);
  wire we_ps = wph_r & (ph_a_r == `ELC_A_PSPC);
  wire we_rc = wph_r & (ph_a_r == `ELC_A_RCFG);
  wire we_pw = wph_r & (ph_a_r == `ELC_A_PWR);
  wire we_ml = wph_r & (ph_a_r == `ELC_A_MACL);
  wire we_mh = wph_r & (ph_a_r == `ELC_A_MACH);

  // Link state derived from negotiation or fixed mode
  wire an_en = pctl_r[`ELC_B_ANEN];
  wire an_done = an_r == AN_DONE;
  assign spd100 = an_done ? res_r[1] : pctl_r[`ELC_B_SPD];
  assign full_dup = an_done ? res_r[0] : pctl_r[`ELC_B_DUP];
  wire int_lbk = pctl_r[`ELC_B_LBK];
  wire rlbk_act = pspc_r[`ELC_B_RLBK] & spd100 & ~int_lbk;
  wire pause_en = an_done & res_r[0] & pse_r;
  wire paused = ptime_r != 16'h0000;
  wire [47:0] mac = {mach_r, macl_r};
  wire [15:0] cmn = padv_r & flp_rx_word; // Common abilities

  // Status word read back by software
  wire [31:0] stat = {ptime_r, 8'h00, paused, pause_en, full_dup, spd100,
                      an_done, link_ok, col_r, crs_r};

  // Read selection, zero when unmapped, or when asleep except for the power register
  wire [31:0] rd_val = !acc_ok(pwr_r, a) ? 32'h0000_0000 :
    (a == `ELC_A_BMODE) ? {31'h0000_0000, sw_rst_r} :
    (a == `ELC_A_PCTL) ? {16'h0000, pctl_r} :
    (a == `ELC_A_PADV) ? {16'h0000, padv_r} :
    (a == `ELC_A_PSPC) ? {16'h0000, pspc_r} :
    (a == `ELC_A_RCFG) ? rcfg_r :
    (a == `ELC_A_PWR) ? {16'h0000, pme_sts_r, 13'h0000, pwr_r} :
    (a == `ELC_A_STAT) ? stat :
    (a == `ELC_A_MACL) ? macl_r :
    (a == `ELC_A_MACH) ? {16'h0000, mach_r} : 32'h0000_0000;

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  // ==========================================
  // Bus slave
  // ==========================================
  // Latch address phase; read data ready for the data phase
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wph_r <= 1'b0;
      ph_a_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
    end else begin
      wph_r <= addr_ph & hwrite & acc_ok(pwr_r, a);
      ph_a_r <= a;
      if (addr_ph && !hwrite) hrdata_r <= rd_val;
    end
  end

  // Whole-block reset: one cycle high, then clears with registers, negotiation, carrier window, pause and wake logic
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin // Host holds this low 100us at least
      sw_rst_r <= 1'b0;
    end else if (chip_rst) begin
      sw_rst_r <= 1'b0;
    end else if (we_bm) begin
      sw_rst_r <= hwdata[`ELC_B_SWRST];
    end
  end

  // Transceiver registers, reset by either reset
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pctl_r <= `ELC_PCTL_RST;
      padv_r <= `ELC_PADV_RST;
      pspc_r <= `ELC_PSPC_RST;
    end else if (phy_clr) begin // Self-clearing bit 15 falls here
      pctl_r <= `ELC_PCTL_RST;
      padv_r <= `ELC_PADV_RST;
      pspc_r <= `ELC_PSPC_RST;
    end else begin
      if (we_pc) pctl_r <= hwdata[15:0];
      if (we_pa) padv_r <= hwdata[15:0];
      if (we_ps) pspc_r <= hwdata[15:0];
    end
  end

  // Controller registers; wake status set beats clear
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rcfg_r <= 32'h0000_0000;
      pwr_r <= ELC_D0;
      pme_sts_r <= 1'b0;
      macl_r <= 32'h0000_0000;
      mach_r <= 16'h0000;
    end else if (chip_rst) begin
      rcfg_r <= 32'h0000_0000;
      pwr_r <= ELC_D0;
      pme_sts_r <= 1'b0;
      macl_r <= 32'h0000_0000;
      mach_r <= 16'h0000;
    end else begin
      if (we_rc) rcfg_r <= hwdata;
      if (we_pw) pwr_r <= elc_pwr_e'(hwdata[1:0]);
      if (we_ml) macl_r <= hwdata;
      if (we_mh) mach_r <= hwdata[15:0];
      if (wake_hit) pme_sts_r <= 1'b1;
      else if (we_pw && hwdata[`ELC_B_PME]) pme_sts_r <= 1'b0;
    end
  end

  // ==========================================
  // Carrier, collision and loopback paths
  // ==========================================
  // Internal loopback feeds transmit coder output back in
  wire tx_src = spd100 ? tx_nrzi_bit : tx_manch_bit;
  wire rx_bit = int_lbk ? tx_src : line_rx_bit;
  wire tx_line = rlbk_act ? line_rx_bit : tx_src;

  // Window over received bits; end code drops carrier
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sr_r <= 10'h3FF;
      crs_rx_r <= 1'b0;
    end else if (phy_clr || rx_end) begin
      sr_r <= 10'h3FF;
      crs_rx_r <= 1'b0;
    end else begin
      sr_r <= {sr_r[8:0], rx_bit};
      if (zeros2(sr_r)) crs_rx_r <= 1'b1;
    end
  end

  // Registered MAC indications and serial outputs
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      crs_r <= 1'b0;
      col_r <= 1'b0;
      rx_path_r <= 1'b1;
      line_tx_r <= 1'b1;
      line_oe_r <= 1'b0;
    end else begin
      crs_r <= full_dup ? crs_rx_r : (crs_rx_r | tx_en);
      col_r <= ~full_dup & tx_en & crs_rx_r;
      rx_path_r <= rx_bit;
      line_tx_r <= tx_line;
      line_oe_r <= ~int_lbk; // Line isolated in loopback
    end
  end
  assign crs = crs_r;
  assign col = col_r;
  assign rx_path_bit = rx_path_r;
  assign line_tx_bit = line_tx_r;
  assign line_tx_oe = line_oe_r;

  // ==========================================
  // Negotiation
  // ==========================================
  // Starts from reset when enabled, else waits for the enable
  always_comb begin
    an_nxt = an_r;
    case (an_r)
      AN_OFF: if (an_en) an_nxt = AN_SEND;
      AN_SEND: if (!an_en) an_nxt = AN_OFF;
        else if (flp_rx_vld) an_nxt = AN_DONE;
      AN_DONE: if (!an_en) an_nxt = AN_OFF;
      default: an_nxt = AN_OFF;
    endcase
  end

  // Highest common mode, fastest full duplex first
  wire [1:0] res_val = cmn[`ELC_B_AB_100F] ? 2'h3 :
    cmn[`ELC_B_AB_100H] ? 2'h2 : cmn[`ELC_B_AB_10F] ? 2'h1 : 2'h0;

  // State and captured resolution
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      an_r <= AN_OFF;
      res_r <= 2'h0;
      pse_r <= 1'b0;
    end else if (phy_clr) begin
      an_r <= AN_OFF;
      res_r <= 2'h0;
      pse_r <= 1'b0;
    end else begin
      an_r <= an_nxt;
      if (an_r == AN_SEND && an_en && flp_rx_vld) begin
        res_r <= res_val;
        pse_r <= cmn[`ELC_B_AB_PSE];
      end
    end
  end
  assign flp_tx_en = an_r == AN_SEND;
  assign flp_tx_word = padv_r;

  // ==========================================
  // Pause flow control
  // ==========================================
  // Only pause requests count; other opcodes pass by
  wire pause_load = ctl_frm.vld & (ctl_frm.opcode == `ELC_OP_PAUSE)
                    & pause_en & rx_ok;
  wire [12:0] slot_last = spd100 ? 13'(`ELC_SLOT100_CYC - 1) : 13'(SLOT10_CYC - 1);
  wire slot_end = slot_r == slot_last;

  // Timer counts whole slots; reload restarts the slot
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ptime_r <= 16'h0000;
      slot_r <= 13'h0000;
    end else if (chip_rst || !pause_en) begin
      ptime_r <= 16'h0000;
      slot_r <= 13'h0000;
    end else if (pause_load) begin // Zero ends pause at once
      ptime_r <= ctl_frm.param;
      slot_r <= 13'h0000;
    end else if (paused) begin
      slot_r <= slot_end ? 13'h0000 : slot_r + 13'h0001;
      if (slot_end) ptime_r <= ptime_r - 16'h0001;
    end
  end

  // Only frame starts are gated; tx_en in flight is untouched
  assign tx_start_ok = ~paused & (pwr_r == ELC_D0);
  assign rx_ok = pwr_r == ELC_D0;

  // ==========================================
  // Wake pattern detection
  // ==========================================
  wire wake_ok = rcfg_r[`ELC_B_WAKE] & (pwr_r != ELC_D2) & (pwr_r != ELC_D3H);
  wire ff_byte = rxb.data == 8'hFF;
  wire ff6 = ff_r == 3'h6;
  wire adv = ff6 & (rxb.data == mac_byte(mac, pos_r)) & ~found_r;
  wire done_now = adv & (pos_r == 3'h5) & (rep_r == 4'hF);
  wire hold = ff6 & (pos_r == 3'h0) & (rep_r == 4'h0) & ff_byte;
  assign wake_hit = rxb.vld & rxb.last & (found_r | done_now)
                    & rxb.addr_ok & rxb.crc_ok & wake_ok;

  // Six FF then sixteen address copies; later runs also count
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ff_r <= 3'h0;
      pos_r <= 3'h0;
      rep_r <= 4'h0;
      found_r <= 1'b0;
    end else if (chip_rst || (rxb.vld && rxb.last) || !wake_ok) begin
      ff_r <= 3'h0;
      pos_r <= 3'h0;
      rep_r <= 4'h0;
      found_r <= 1'b0;
    end else if (rxb.vld && !found_r && !hold) begin
      if (adv) begin
        pos_r <= (pos_r == 3'h5) ? 3'h0 : pos_r + 3'h1;
        if (pos_r == 3'h5) rep_r <= rep_r + 4'h1;
        found_r <= done_now;
      end else if (!ff6 && ff_byte) begin
        ff_r <= ff_r + 3'h1;
      end else begin
        ff_r <= ff_byte ? 3'h1 : 3'h0;
        pos_r <= 3'h0;
        rep_r <= 4'h0;
      end
    end
  end
  assign pme_b_o = 1'b0; // Open drain: only ever pulls low
  assign pme_b_oe = pme_sts_r;

  // ==========================================
  // LEDs
  // ==========================================
  // Free-running dividers; blink phase is not tied to activity start
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      act_cnt_r <= 23'h000000;
      col_cnt_r <= 23'h000000;
      act_blk_r <= 1'b0;
      col_blk_r <= 1'b0;
    end else begin
      act_cnt_r <= (act_cnt_r == 23'(ACT_HALF - 1)) ? 23'h000000 : act_cnt_r + 23'h000001;
      col_cnt_r <= (col_cnt_r == 23'(COL_HALF - 1)) ? 23'h000000 : col_cnt_r + 23'h000001;
      if (act_cnt_r == 23'(ACT_HALF - 1)) act_blk_r <= ~act_blk_r;
      if (col_cnt_r == 23'(COL_HALF - 1)) col_blk_r <= ~col_blk_r;
    end
  end

  // Scheme select: bit 5 of the specific control register
  wire act = tx_en | crs_rx_r;
  wire fdc = col_r ? col_blk_r : full_dup;
  wire [3:0] led3 = {1'b0, fdc, (act & ~col_r) ? act_blk_r : link_ok, spd100};
  wire [3:0] led4 = {fdc, act & act_blk_r, link_ok & ~spd100, link_ok & spd100};
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) led_r <= 4'h0;
    else led_r <= pspc_r[`ELC_B_LED4] ? led4 : led3;
  end
  assign led = led_r;

  // ==========================================
  // Checks
  // ==========================================
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  property p_crs_set;
    (zeros2(sr_r) && !rx_end && !phy_clr) |=> crs_rx_r;
  endproperty
  a_crs_set: assert property (p_crs_set) else $error("carrier not raised");
  property p_crs_mode;
    !chip_rst |=> crs_r == ($past(full_dup) ? $past(crs_rx_r)
                           : ($past(crs_rx_r) | $past(tx_en)));
  endproperty
  a_crs_mode: assert property (p_crs_mode) else $error("carrier mode wrong");
  property p_col_fd;
    full_dup |=> !col_r;
  endproperty
  a_col_fd: assert property (p_col_fd) else $error("collision in full duplex");
  property p_iso;
    int_lbk |=> !line_tx_oe;
  endproperty
  a_iso: assert property (p_iso) else $error("line driven in loopback");
  property p_lbk100;
    (int_lbk && spd100) |=> rx_path_bit == $past(tx_nrzi_bit);
  endproperty
  a_lbk100: assert property (p_lbk100) else $error("100M loopback path");
  property p_lbk10;
    (int_lbk && !spd100) |=> rx_path_bit == $past(tx_manch_bit);
  endproperty
  a_lbk10: assert property (p_lbk10) else $error("10M loopback path");
  property p_rlbk;
    rlbk_act |=> line_tx_bit == $past(line_rx_bit) && line_tx_oe;
  endproperty
  a_rlbk: assert property (p_rlbk) else $error("remote loopback path");
  property p_an_start;
    (an_r == AN_OFF && an_en && !phy_clr) |=> flp_tx_en;
  endproperty
  a_an_start: assert property (p_an_start) else $error("negotiation idle");
  property p_an_prio;
    (an_r == AN_SEND && an_en && flp_rx_vld && cmn[8] && !phy_clr)
      |=> spd100 && full_dup;
  endproperty
  a_an_prio: assert property (p_an_prio) else $error("wrong priority");
  property p_pause_load;
    (pause_load && !chip_rst) |=> ptime_r == $past(ctl_frm.param)
      && (!tx_start_ok || $past(ctl_frm.param) == 16'h0000);
  endproperty
  a_pause_load: assert property (p_pause_load) else $error("pause not loaded");
  property p_pause_gate;
    paused |-> !tx_start_ok;
  endproperty
  a_pause_gate: assert property (p_pause_gate) else $error("start while paused");
  property p_slot;
    (paused && !slot_end && !pause_load && pause_en && !chip_rst) |=> ptime_r == $past(ptime_r);
  endproperty
  a_slot: assert property (p_slot) else $error("timer left slot early");
  property p_prst;
    phy_rst |=> !pctl_r[15] && padv_r == `ELC_PADV_RST;
  endproperty
  a_prst: assert property (p_prst) else $error("transceiver reset stuck");
  property p_swrst;
    sw_rst_r |=> !sw_rst_r && pwr_r == ELC_D0 && !paused;
  endproperty
  a_swrst: assert property (p_swrst) else $error("block reset stuck");
  property p_wake;
    wake_hit |=> pme_sts_r && pme_b_oe;
  endproperty
  a_wake: assert property (p_wake) else $error("wake not flagged");
  property p_d2;
    (pwr_r == ELC_D2) |-> !tx_start_ok && !rx_ok && !wake_hit;
  endproperty
  a_d2: assert property (p_d2) else $error("traffic in D2");
  c_pause: cover property (pause_load ##1 paused);
  c_wake: cover property (wake_hit);
  c_an: cover property (an_r == AN_SEND ##1 an_r == AN_DONE);
  c_col: cover property (col_r);
endmodule

// ==== src/elc_params.svh ====
// Offsets, field positions, reset values and timing counts
// Assumes inclusion by bare name from the link control design file
`ifndef ELC_PARAMS_SVH
`define ELC_PARAMS_SVH
// Register byte offsets
`define ELC_A_BMODE 8'h00
`define ELC_A_PCTL 8'h04
`define ELC_A_PADV 8'h08
`define ELC_A_PSPC 8'h0C
`define ELC_A_RCFG 8'h10
`define ELC_A_PWR 8'h14
`define ELC_A_STAT 8'h18
`define ELC_A_MACL 8'h1C
`define ELC_A_MACH 8'h20
// Field positions
`define ELC_B_SWRST 0
`define ELC_B_PRST 15
`define ELC_B_LBK 14
`define ELC_B_SPD 13
`define ELC_B_ANEN 12
`define ELC_B_DUP 8
`define ELC_B_RLBK 3
`define ELC_B_LED4 5
`define ELC_B_WAKE 18
`define ELC_B_PME 15
`define ELC_B_AB_PSE 10
`define ELC_B_AB_100F 8
`define ELC_B_AB_100H 7
`define ELC_B_AB_10F 6
// Reset values
`define ELC_PCTL_RST 16'h3100
`define ELC_PADV_RST 16'h05E1
`define ELC_PSPC_RST 16'h0000
// Control opcode of a pause request
`define ELC_OP_PAUSE 16'h0001
// Timing
`define ELC_CLK_NS 10
`define ELC_SLOT_BITS 512
`define ELC_BIT100_NS 10
`define ELC_BIT10_NS 100
`define ELC_RST_MIN_US 100
`define ELC_ACT_HZ 10
`define ELC_COL_HZ 20
`define ELC_SLOT100_CYC (`ELC_SLOT_BITS * `ELC_BIT100_NS / `ELC_CLK_NS)
`define ELC_SLOT10_CYC (`ELC_SLOT_BITS * `ELC_BIT10_NS / `ELC_CLK_NS)
`define ELC_ACT_HALF (1000000000 / (`ELC_ACT_HZ * 2 * `ELC_CLK_NS))
`define ELC_COL_HALF (1000000000 / (`ELC_COL_HZ * 2 * `ELC_CLK_NS))
`endif

// ==== src/elc_pkg.sv ====
// Types shared by the link control block and its bench
// Assumes nothing beyond a SystemVerilog compiler
package elc_pkg;
  // Power states, in field order
  typedef enum logic [1:0] {ELC_D0, ELC_D1, ELC_D2, ELC_D3H} elc_pwr_e;
  // Negotiation states
  typedef enum logic [1:0] {AN_OFF, AN_SEND, AN_DONE} elc_an_e;
  // Decoded MAC control frame, one-cycle strobe
  typedef struct packed {
    logic vld;
    logic [15:0] opcode;
    logic [15:0] param;
  } elc_ctl_s;
  // Received byte stream with end-of-frame verdicts
  typedef struct packed {
    logic vld;
    logic [7:0] data;
    logic last;
    logic addr_ok;
    logic crc_ok;
  } elc_rxb_s;
endpackage
